// ===== rtl/sbta_map.svh
// Function
// - After reset the CPU master wins ties and outranks the other two masters.
// - Each master has a programmable priority level; 15 is the top rank.
// - Token scheme guarantees bandwidth; unused share goes to other requesters.
// - Every refresh period start loads each token counter with its weight.
// - Refresh period length in clock cycles comes from a programmable setting.
// - Each cycle a master holds the bus its token counter drops by one.
// - Masters with tokens always beat masters without tokens.
// - Within each token group, programmed priority levels pick the winner.
// - A weight of zero means tokens never run out.
// - Chip registers are 32 bits; only word accesses; bursts accepted.
// - Chip-register writes are posted into a one-word buffer, releasing the bus.
// - A register write meeting a full buffer stalls the bus until it drains.
// - A chip-register read stalls the bus until read data returns.
// - A register read after a write waits until the buffered write completes.
// - Subrange at 0x70000000 is local, fast, few-cycle registers.
// - Subrange at 0x71000000 goes to the switch register bus, with fast targets.
// - Flash window reads start flash reads; flash writes are refused.
// - DRAM window accesses go to the DDR3 memory controller.
// - PCIe window accesses become outbound PCIe reads and writes.
`ifndef SBTA_MAP_SVH
`define SBTA_MAP_SVH
`define SBTA_OFS_PRIO_CPU    6'h00
`define SBTA_OFS_PRIO_PCIE   6'h04
`define SBTA_OFS_PRIO_BRIDGE 6'h08
`define SBTA_OFS_TOKEN_EN    6'h0C
`define SBTA_OFS_PERIOD      6'h10
`define SBTA_OFS_CPU_TOKEN_WEIGHT      6'h14
`define SBTA_OFS_PCIE_TOKEN_WEIGHT     6'h18
`define SBTA_OFS_WT_BRIDGE   6'h1C
`define SBTA_OFS_STATUS      6'h20
`define SBTA_OFS_TOK_CPU     6'h24
`define SBTA_OFS_TOK_PCIE    6'h28
`define SBTA_OFS_TOK_BRIDGE  6'h2C
`define SBTA_RST_PRIO_CPU    4'h2
`define SBTA_RST_PRIO_PCIE   4'h1
`define SBTA_RST_PRIO_BRIDGE 4'h0
`define SBTA_RST_PERIOD      16'h0800
`define SBTA_BASE_FLASH      4'h4
`define SBTA_BASE_CHIPREG    4'h7
`define SBTA_SUB_LOCAL       4'h0
`define SBTA_SUB_SWITCH      4'h1
`define SBTA_FAST_SW_LO      8'h00
`define SBTA_FAST_SW_HI      8'h01
`endif

// ===== rtl/sbta_pkg.sv
package sbta_pkg;
   localparam int SBTA_NMST = 3;
   localparam int SBTA_TW   = 16;

   typedef enum logic [2:0] {
      SBTA_S_IDLE = 3'b001,
      SBTA_S_HOLD = 3'b010,
      SBTA_S_WAIT = 3'b100
   } sbta_fsm_t;

   typedef enum logic [2:0] {
      SBTA_T_NONE    = 3'h0,
      SBTA_T_LOCAL   = 3'h1,
      SBTA_T_SW_FAST = 3'h2,
      SBTA_T_SW_SLOW = 3'h3,
      SBTA_T_FLASH   = 3'h4,
      SBTA_T_DRAM    = 3'h5,
      SBTA_T_PCIE    = 3'h6
   } sbta_tgt_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } sbta_mreq_t;

   typedef struct packed {
      logic        done;
      logic        err;
      logic [31:0] rdata;
   } sbta_mrsp_t;

   typedef struct packed {
      logic        valid;
      sbta_tgt_t   tgt;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } sbta_treq_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } sbta_trsp_t;
endpackage

// ===== rtl/sbta_arbiter.sv
`include "sbta_map.svh"

module sbta_arbiter (
   input  wire logic                               hclk,
   input  wire logic                               hresetn,
   input  wire logic                               hsel,
   input  wire logic [31:0]                        haddr,
   input  wire logic [1:0]                         htrans,
   input  wire logic                               hwrite,
   input  wire logic [2:0]                         hsize,
   input  wire logic                               hready,
   input  wire logic [31:0]                        hwdata,
   output logic                                    hreadyout,
   output logic                                    hresp,
   output logic [31:0]                             hrdata,
   input  wire sbta_pkg::sbta_mreq_t [2:0]         mreq,
   output sbta_pkg::sbta_mrsp_t [2:0]              mrsp,
   output logic [2:0]                              grant,
   output sbta_pkg::sbta_treq_t                    treq,
   input  wire sbta_pkg::sbta_trsp_t               trsp
);
   import sbta_pkg::*;

   typedef struct packed {
      sbta_fsm_t                   fsm;
      logic [1:0]                  owner;
      sbta_mreq_t                  cur;
      logic                        wb_valid;
      sbta_tgt_t                   wb_tgt;
      logic [31:0]                 wb_addr;
      logic [31:0]                 wb_data;
      logic                        tp_busy;
      logic                        tp_from_wb;
      sbta_treq_t                  treq;
      logic [2:0]                  grant;
      sbta_mrsp_t [2:0]            mrsp;
      logic [2:0][3:0]             prio;
      logic                        token_en;
      logic [SBTA_TW-1:0]          period;
      logic [2:0][SBTA_TW-1:0]     weight;
      logic [2:0][SBTA_TW-1:0]     tokens;
      logic [SBTA_TW-1:0]          rcnt;
      logic                        wr_pend;
      logic [5:0]                  wr_ofs;
      logic                        hreadyout;
      logic [31:0]                 hrdata;
   } sbta_state_t;

   sbta_state_t st_r;
   sbta_state_t st_nxt;

   // Region decode of a word address; NONE means unmapped
   function automatic sbta_tgt_t decode(input logic [31:0] a);
      sbta_tgt_t t;
      t = SBTA_T_NONE;
      if (a[31:30] == 2'b00) begin
         t = SBTA_T_DRAM;
      end else if (a[31:28] == `SBTA_BASE_FLASH) begin
         t = SBTA_T_FLASH;
      end else if (a[31:28] == `SBTA_BASE_CHIPREG) begin
         if (a[27:24] == `SBTA_SUB_LOCAL) begin
            t = SBTA_T_LOCAL;
         end else if (a[27:24] == `SBTA_SUB_SWITCH) begin
            if (a[23:16] == `SBTA_FAST_SW_LO || a[23:16] == `SBTA_FAST_SW_HI) begin
               t = SBTA_T_SW_FAST;
            end else begin
               t = SBTA_T_SW_SLOW;
            end
         end
      end else if (a[31:30] == 2'b10) begin
         t = SBTA_T_DRAM;
      end else if (a[31:30] == 2'b11) begin
         t = SBTA_T_PCIE;
      end
      return t;
   endfunction

   function automatic logic is_chipreg(input sbta_tgt_t t);
      return (t == SBTA_T_LOCAL) || (t == SBTA_T_SW_FAST) || (t == SBTA_T_SW_SLOW);
   endfunction

   function automatic logic [31:0] reg_read(input sbta_state_t s, input logic [5:0] ofs);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (ofs)
         `SBTA_OFS_PRIO_CPU:    d = {28'h0000000, s.prio[0]};
         `SBTA_OFS_PRIO_PCIE:   d = {28'h0000000, s.prio[1]};
         `SBTA_OFS_PRIO_BRIDGE: d = {28'h0000000, s.prio[2]};
         `SBTA_OFS_TOKEN_EN:    d = {31'h00000000, s.token_en};
         `SBTA_OFS_PERIOD:      d = {16'h0000, s.period};
         `SBTA_OFS_CPU_TOKEN_WEIGHT:      d = {16'h0000, s.weight[0]};
         `SBTA_OFS_PCIE_TOKEN_WEIGHT:     d = {16'h0000, s.weight[1]};
         `SBTA_OFS_WT_BRIDGE:   d = {16'h0000, s.weight[2]};
         `SBTA_OFS_STATUS:      d = {22'h000000, s.grant, s.fsm, s.tp_busy, s.wb_valid,
                                     s.owner};
         `SBTA_OFS_TOK_CPU:     d = {16'h0000, s.tokens[0]};
         `SBTA_OFS_TOK_PCIE:    d = {16'h0000, s.tokens[1]};
         `SBTA_OFS_TOK_BRIDGE:  d = {16'h0000, s.tokens[2]};
         default:               d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   logic [2:0]  has_tok;
   logic [4:0]  score [3];
   logic [4:0]  best_score;
   logic [1:0]  best;
   logic        found;
   sbta_tgt_t   cur_tgt;
   logic        refresh;

   always_comb begin
      st_nxt = st_r;
      best_score = 5'h00;
      best = 2'd0;
      found = 1'b0;
      for (int i = 0; i < SBTA_NMST; i++) begin
         st_nxt.mrsp[i].done = 1'b0;
         st_nxt.mrsp[i].err = 1'b0;
         has_tok[i] = (st_r.weight[i] == '0) || (st_r.tokens[i] != '0);
         // Token group bit sits above the priority level
         score[i] = {(st_r.token_en ? has_tok[i] : 1'b1), st_r.prio[i]};
      end

      // Strict compare keeps the lower index on ties: CPU, then PCIe, then bridge
      for (int i = 0; i < SBTA_NMST; i++) begin
         // A master still showing its done pulse has not yet dropped its request
         if (mreq[i].valid && !st_r.mrsp[i].done &&
             (!found || score[i] > best_score)) begin
            found = 1'b1;
            best = 2'(i);
            best_score = score[i];
         end
      end

      // Refresh counter and token accounting
      refresh = ({1'b0, st_r.rcnt} + 17'h00001) >= {1'b0, st_r.period};
      if (refresh) begin
         st_nxt.rcnt = '0;
         st_nxt.tokens = st_r.weight;
      end else begin
         st_nxt.rcnt = st_r.rcnt + 16'h0001;
         if (st_r.fsm != SBTA_S_IDLE && st_r.tokens[st_r.owner] != '0) begin
            st_nxt.tokens[st_r.owner] = st_r.tokens[st_r.owner] - 16'h0001;
         end
      end

      // Target port completion
      if (st_r.tp_busy && trsp.ack) begin
         st_nxt.tp_busy = 1'b0;
         st_nxt.treq.valid = 1'b0;
         if (st_r.tp_from_wb) begin
            st_nxt.wb_valid = 1'b0;
         end else if (st_r.fsm == SBTA_S_WAIT) begin
            st_nxt.mrsp[st_r.owner].done = 1'b1;
            st_nxt.mrsp[st_r.owner].rdata = trsp.rdata;
            st_nxt.fsm = SBTA_S_IDLE;
            st_nxt.grant = 3'b000;
         end
      end

      cur_tgt = decode(st_r.cur.addr);
      case (st_r.fsm)
         SBTA_S_IDLE: begin
            if (found) begin
               st_nxt.owner = best;
               st_nxt.cur = mreq[best];
               st_nxt.grant = 3'b001 << best;
               st_nxt.fsm = SBTA_S_HOLD;
            end
         end
         SBTA_S_HOLD: begin
            if (cur_tgt == SBTA_T_NONE || (cur_tgt == SBTA_T_FLASH && st_r.cur.write)) begin
               st_nxt.mrsp[st_r.owner].done = 1'b1;
               st_nxt.mrsp[st_r.owner].err = 1'b1;
               st_nxt.fsm = SBTA_S_IDLE;
               st_nxt.grant = 3'b000;
            end else if (is_chipreg(cur_tgt) && st_r.cur.write) begin
               // Bus stays held while an earlier posted write is pending
               if (!st_nxt.wb_valid) begin
                  st_nxt.wb_valid = 1'b1;
                  st_nxt.wb_tgt = cur_tgt;
                  st_nxt.wb_addr = {st_r.cur.addr[31:2], 2'b00};
                  st_nxt.wb_data = st_r.cur.wdata;
                  st_nxt.mrsp[st_r.owner].done = 1'b1;
                  st_nxt.fsm = SBTA_S_IDLE;
                  st_nxt.grant = 3'b000;
               end
            end else if (!st_nxt.wb_valid && !st_r.tp_busy) begin
               st_nxt.treq.valid = 1'b1;
               st_nxt.treq.tgt = cur_tgt;
               st_nxt.treq.write = st_r.cur.write;
               st_nxt.treq.addr = {st_r.cur.addr[31:2], 2'b00};
               st_nxt.treq.wdata = st_r.cur.wdata;
               st_nxt.tp_busy = 1'b1;
               st_nxt.tp_from_wb = 1'b0;
               st_nxt.fsm = SBTA_S_WAIT;
            end
         end
         SBTA_S_WAIT: begin
            st_nxt.fsm = st_nxt.fsm;
         end
         default: begin
            st_nxt.fsm = SBTA_S_IDLE;
            st_nxt.grant = 3'b000;
         end
      endcase

      // Drain the posted write once the target port is free
      if (st_r.wb_valid && !st_r.tp_busy && !st_nxt.tp_busy) begin
         st_nxt.treq.valid = 1'b1;
         st_nxt.treq.tgt = st_r.wb_tgt;
         st_nxt.treq.write = 1'b1;
         st_nxt.treq.addr = st_r.wb_addr;
         st_nxt.treq.wdata = st_r.wb_data;
         st_nxt.tp_busy = 1'b1;
         st_nxt.tp_from_wb = 1'b1;
      end

      // AHB-Lite data phase of a write
      if (st_r.wr_pend) begin
         case (st_r.wr_ofs)
            `SBTA_OFS_PRIO_CPU:    st_nxt.prio[0] = hwdata[3:0];
            `SBTA_OFS_PRIO_PCIE:   st_nxt.prio[1] = hwdata[3:0];
            `SBTA_OFS_PRIO_BRIDGE: st_nxt.prio[2] = hwdata[3:0];
            `SBTA_OFS_TOKEN_EN:    st_nxt.token_en = hwdata[0];
            `SBTA_OFS_PERIOD:      st_nxt.period = hwdata[15:0];
            `SBTA_OFS_CPU_TOKEN_WEIGHT:      st_nxt.weight[0] = hwdata[15:0];
            `SBTA_OFS_PCIE_TOKEN_WEIGHT:     st_nxt.weight[1] = hwdata[15:0];
            `SBTA_OFS_WT_BRIDGE:   st_nxt.weight[2] = hwdata[15:0];
            default:               st_nxt.wr_pend = 1'b0;
         endcase
      end

      // AHB-Lite address phase; reads see a write completing in the same cycle
      st_nxt.wr_pend = 1'b0;
      st_nxt.hreadyout = 1'b1;
      if (hsel && htrans[1] && hready) begin
         if (hwrite) begin
            // Writes above the register block are dropped, not aliased
            st_nxt.wr_pend = (haddr[31:6] == 26'h0000000);
            st_nxt.wr_ofs = {haddr[5:2], 2'b00};
         end else begin
            st_nxt.hrdata = (haddr[31:6] == 26'h0000000) ?
                            reg_read(st_nxt, {haddr[5:2], 2'b00}) : 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= '0;
         st_r.fsm <= SBTA_S_IDLE;
         st_r.prio <= {`SBTA_RST_PRIO_BRIDGE, `SBTA_RST_PRIO_PCIE, `SBTA_RST_PRIO_CPU};
         st_r.period <= `SBTA_RST_PERIOD;
         st_r.hreadyout <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hreadyout = st_r.hreadyout;
   assign hresp     = 1'b0;
   assign hrdata    = st_r.hrdata;
   assign mrsp      = st_r.mrsp;
   assign grant     = st_r.grant;
   assign treq      = st_r.treq;

endmodule

// ===== test/sbta_target_model.sv
module sbta_target_model
   import sbta_pkg::*;
(
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic [3:0]          dly,
   input  wire sbta_pkg::sbta_treq_t treq,
   output sbta_pkg::sbta_trsp_t      trsp,
   output logic [7:0]               ack_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  wait_r;
   logic [31:0] noise_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wait_r <= 4'h0;
         trsp <= '0;
         ack_cnt <= 8'h00;
         noise_r <= 32'hC3A5_0F1E;
      end else begin
         noise_r <= {noise_r[30:0], noise_r[31] ^ noise_r[21]};
         trsp.ack <= 1'b0;
         // Read data lines carry junk outside an answer
         trsp.rdata <= noise_r;
         if (treq.valid && !trsp.ack) begin
            if (wait_r >= dly) begin
               trsp.ack <= 1'b1;
               trsp.rdata <= treq.write ? noise_r : ~treq.addr;
               ack_cnt <= ack_cnt + 8'h01;
               wait_r <= 4'h0;
            end else begin
               wait_r <= wait_r + 4'h1;
            end
         end
      end
   end
endmodule

// ===== test/sbta_checker.sv
module sbta_checker
   import sbta_pkg::*;
(
   input wire logic                 hclk,
   input wire logic                 hresetn,
   input wire logic                 hreadyout,
   input wire logic                 hresp,
   input wire sbta_pkg::sbta_mreq_t [2:0] mreq,
   input wire sbta_pkg::sbta_mrsp_t [2:0] mrsp,
   input wire logic [2:0]           grant,
   input wire sbta_pkg::sbta_treq_t treq,
   input wire sbta_pkg::sbta_trsp_t trsp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] vld;
   logic [2:0] done;
   assign vld = {mreq[2].valid, mreq[1].valid, mreq[0].valid};
   assign done = {mrsp[2].done, mrsp[1].done, mrsp[0].done};
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_ready: assert property (hreadyout && !hresp) else $error("bus slave stalled");
   a_one_owner: assert property ($onehot0(grant)) else $error("two owners");
   a_grant_cause: assert property (grant != 3'h0 && $past(grant) == 3'h0
      |-> (grant & $past(vld)) == grant) else $error("grant without request");
   a_read_stall: assert property (treq.valid && !treq.write |-> grant != 3'h0)
      else $error("bus freed during read");
   a_hold_req: assert property (treq.valid && !trsp.ack
      |=> treq.valid && $stable(treq.addr) && $stable(treq.wdata))
      else $error("target request changed");
   a_ack_drop: assert property (treq.valid && trsp.ack |=> !treq.valid)
      else $error("request kept after answer");
   a_done_owner: assert property (done != 3'h0
      |-> (done & ~$past(grant)) == 3'h0) else $error("done to non owner");
   a_map_local: assert property (treq.valid && treq.addr[31:24] == 8'h70
      |-> treq.tgt == SBTA_T_LOCAL) else $error("local map wrong");
   a_map_switch: assert property (treq.valid && treq.addr[31:24] == 8'h71
      |-> treq.tgt == (treq.addr[23:17] == 7'h00 ? SBTA_T_SW_FAST : SBTA_T_SW_SLOW))
      else $error("switch map wrong");
   a_map_dram: assert property (treq.valid && treq.addr[31:30] == 2'b10
      |-> treq.tgt == SBTA_T_DRAM) else $error("dram map wrong");
   a_map_pcie: assert property (treq.valid && treq.addr[31:30] == 2'b11
      |-> treq.tgt == SBTA_T_PCIE) else $error("pcie map wrong");
   a_flash_ro: assert property (treq.valid && treq.tgt == SBTA_T_FLASH |-> !treq.write)
      else $error("flash write issued");
   c_read: cover property (treq.valid && trsp.ack && !treq.write);
   c_contest: cover property (grant[1] && mreq[0].valid);
   c_err: cover property (mrsp[0].err);
endmodule

// ===== test/sbta_arbiter_bench.sv
module sbta_arbiter_bench
   import sbta_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic             hclk = 1'b0;
   logic             hresetn = 1'b0;
   logic             hsel = 1'b0;
   logic             hwrite = 1'b0;
   logic [1:0]       htrans = 2'h0;
   logic [2:0]       hsize = 3'h2;
   logic [31:0]      haddr = 32'h0;
   logic [31:0]      hwdata = 32'h0;
   logic [31:0]      seed = 32'hB7B1;
   logic [3:0]       dly = 4'h0;
   logic             hreadyout;
   logic [31:0]      hrdata;
   logic [2:0]       grant;
   logic [7:0]       ack_cnt;
   sbta_mreq_t [2:0] mreq = '0;
   sbta_mrsp_t [2:0] mrsp;
   sbta_treq_t       treq;
   sbta_trsp_t       trsp;
   int               cyc = 0;
   int               mismatches = 0;
   int               checks_done = 0;
   logic [31:0]      got_rd [3];
   logic             got_err [3];
   logic [7:0]       got_ack [3];
   logic [31:0]      amap [6] = '{32'h7000_0000, 32'h7100_0000, 32'h7120_0000,
                                  32'h4000_0000, 32'h8000_0000, 32'hC000_0000};
   sbta_arbiter i_sbta_arbiter (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hready(hreadyout), .hwdata, .hreadyout, .hresp(), .hrdata, .mreq, .mrsp, .grant,
      .treq, .trsp);
   sbta_target_model i_sbta_target_model (.hclk, .hresetn, .dly, .treq, .trsp, .ack_cnt);
   always #4 hclk = ~hclk;
   always @(posedge hclk) cyc <= hresetn ? cyc + 1 : 0;
   // Masters let go at the done pulse; note what each one got back
   always @(posedge hclk)
      for (int i = 0; i < 3; i++)
         if (mrsp[i].done === 1'b1) begin
            mreq[i].valid <= 1'b0;
            got_rd[i] = mrsp[i].rdata;
            got_err[i] = mrsp[i].err;
            got_ack[i] = ack_cnt;
         end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (!hreadyout);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (!hreadyout);
      rd = hrdata;
   endtask
   task automatic run(input logic [2:0] who, input logic wr, input logic [31:0] a,
                      input logic [2:0] exp);
      @(posedge hclk);
      for (int i = 0; i < 3; i++)
         if (who[i]) mreq[i] <= '{1'b1, wr, a, seed};
      do @(posedge hclk); while (grant == 3'h0);
      check(32'(grant), 32'(exp));
      do @(posedge hclk); while (mreq[0].valid | mreq[1].valid | mreq[2].valid);
      for (int i = 0; i < 3; i++)
         if (who[i] && !wr) check(got_rd[i], ~a);
   endtask
   initial begin
      logic [31:0] rd;
      logic [7:0]  base;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, 32'h00, 32'h0, rd);
      check(rd, 32'h2);
      ahb(1'b0, 32'h10, 32'h0, rd);
      check(rd, 32'h800);
      ahb(1'b0, 32'h3C, 32'h0, rd);
      check(rd, 32'h0);
      run(3'b111, 1'b0, 32'h7000_0040, 3'b001);
      ahb(1'b1, 32'h04, 32'hF, rd);
      run(3'b111, 1'b0, 32'h7000_0044, 3'b010);
      foreach (amap[k]) begin
         seed = xs(seed);
         dly <= seed[3:0];
         run(3'b100, 1'b0, amap[k] | (seed & 32'h0000_FFFC), 3'b100);
         check(32'(got_err[2]), 32'h0);
      end
      run(3'b001, 1'b1, 32'h4000_0010, 3'b001);
      check(32'(got_err[0]), 32'h1);
      run(3'b010, 1'b1, 32'h5000_0000, 3'b010);
      check(32'(got_err[1]), 32'h1);
      dly <= 4'hC;
      base = ack_cnt;
      run(3'b001, 1'b1, 32'h7000_0020, 3'b001);
      check(32'(got_ack[0]), 32'(base));
      run(3'b001, 1'b1, 32'h7000_0024, 3'b001);
      check(32'(got_ack[0]), 32'(base + 8'h01));
      run(3'b001, 1'b0, 32'h7000_0028, 3'b001);
      check(32'(got_ack[0]), 32'(base + 8'h03));
      dly <= 4'h1;
      ahb(1'b1, 32'h18, 32'h2, rd);
      ahb(1'b1, 32'h0C, 32'h1, rd);
      // Default period reloads tokens near cycle 2048
      while (cyc < 2100) @(posedge hclk);
      ahb(1'b0, 32'h28, 32'h0, rd);
      check(rd, 32'h2);
      run(3'b011, 1'b0, 32'h7000_0050, 3'b010);
      ahb(1'b0, 32'h28, 32'h0, rd);
      check(rd, 32'h0);
      run(3'b011, 1'b0, 32'h7000_0054, 3'b001);
      ahb(1'b1, 32'h0C, 32'h0, rd);
      run(3'b011, 1'b0, 32'h7000_0058, 3'b010);
      ahb(1'b1, 32'h10, 32'h12C, rd);
      ahb(1'b1, 32'h0C, 32'h1, rd);
      repeat (310) @(posedge hclk);
      run(3'b011, 1'b0, 32'h7000_005C, 3'b010);
      tally_and_finish;
   end
   // All tests need about 2500 cycles
   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      tally_and_finish;
   end
endmodule

bind sbta_arbiter sbta_checker i_sbta_checker (.hclk, .hresetn, .hreadyout, .hresp, .mreq,
   .mrsp, .grant, .treq, .trsp);
